// [src/bldc_host_params.svh]
// Constants for the motor controller host interface
`ifndef BLDC_HOST_PARAMS_SVH
`define BLDC_HOST_PARAMS_SVH

`define WORD_BITS         16
`define FAULT_BIT         15
`define RUN_BIT           0
`define CLK_PERIOD_NS     10
`define BRAKE_TIME_US     500
`define BRAKE_CYCLES      ((`BRAKE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SHUTDOWN_HOLD_US  1000
`define SHUTDOWN_CYCLES   ((`SHUTDOWN_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define TIMER_DIVIDE      400
`define DIAGNOSTIC_OUT_SEL_RESET    2'h0

`endif

// [src/bldc_host_pkg.sv]
// Types shared by the motor controller host interface
package bldc_host_pkg;

    typedef enum logic [1:0] {
        DIAGNOSTIC_OUT_FAULT,
        DIAGNOSTIC_OUT_TIMER,
        DIAGNOSTIC_OUT_VDS,
        DIAGNOSTIC_OUT_RUNNING
    } diagnostic_out_sel_t;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } gate_t;

    typedef struct packed {
        logic       valid;
        logic [15:0] data;
    } word_t;

endpackage

// [src/pin_sync.sv]
// Two-stage synchroniser for a group of pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Pins
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin
        $error("pin_sync width must be positive");
    end

    // Reset value one: every synchronised pin idles high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1   <= '1;
            sync_out <= '1;
        end else if (clk_en) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// [src/low_timer.sv]
// Counts how long an input has stayed low, flags when a limit passes
`timescale 1ns/10ps
module low_timer #(
    parameter int LIMIT = 50000
) (
    // Clock
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    // Level
    input  wire logic level,
    output logic      expired
);
    localparam int CW = $clog2(LIMIT + 1);
    logic [CW-1:0] count;

    if (LIMIT < 1) begin
        $error("low_timer limit must be positive");
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (clk_en) begin
            if (level) begin
                count   <= '0;
                expired <= 1'b0;
            end else if (count < CW'(LIMIT)) begin
                count <= count + CW'(1);
            end else begin
                expired <= 1'b1;
            end
        end
    end
endmodule

// [src/bldc_host_if.sv]
// Host-facing serial port, PWM, reset and output logic of the controller
`include "bldc_host_params.svh"
`timescale 1ns/10ps
module bldc_host_if #(
    parameter int BRAKE_CYCLES    = `BRAKE_CYCLES,
    parameter int SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES,
    parameter int TIMER_DIVIDE    = `TIMER_DIVIDE
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // Serial pins
    input  wire logic                serial_clk,
    input  wire logic                serial_in,
    input  wire logic                access_strobe_n,
    output logic                     serial_out,
    output logic                     serial_out_oe,
    // Received words
    output bldc_host_pkg::word_t     rx_word,
    // Control and diagnostics from the core
    input  wire logic                run_enable,
    input  wire bldc_host_pkg::diagnostic_out_sel_t diagnostic_select,
    input  wire logic [14:0]         diagnostic_out_bits,
    input  wire logic                fault_event,
    input  wire logic                sensorless_running,
    input  wire logic                vds_level,
    // Commutation
    input  wire logic [2:0]          phase_high,
    input  wire logic [2:0]          phase_low,
    input  wire logic                zero_cross,
    input  wire logic                commutate,
    // Other pins
    input  wire logic                pwm_in,
    input  wire logic                fault_clear_sleep_n,
    output bldc_host_pkg::gate_t     gate_drive,
    output logic                     sleep,
    output logic                     summary_fault_flag,
    output logic                     diagnostic_out,
    output logic                     speed_pulse_out
);
    import bldc_host_pkg::*;

    localparam int DW = $clog2(TIMER_DIVIDE);

    if (TIMER_DIVIDE < `TIMER_DIVIDE || TIMER_DIVIDE % 2 != 0) begin
        $error("timer divide must be even and at least 400");
    end
    if (BRAKE_CYCLES < 1 || SHUTDOWN_CYCLES < 1) begin
        $error("brake and shutdown counts must be positive");
    end
    if ($bits(word_t) != `WORD_BITS + 1) begin
        $error("received word must carry 16 data bits");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_sync;
    logic       sclk;
    logic       sdin;
    logic       strobe_n;
    logic       pwm;
    logic       rst_pin_n;

    // Two stages on every pin: the host's lines run on no clock of ours
    pin_sync #(.WIDTH(5)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({serial_clk, serial_in, access_strobe_n, pwm_in,
                    fault_clear_sleep_n}),
        .sync_out (pins_sync)
    );

    assign {sclk, sdin, strobe_n, pwm, rst_pin_n} = pins_sync;

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic sclk_d;
    logic strobe_d;
    logic rst_pin_d;

    // Idle high after reset, as the pins are, so no false edge follows
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_d    <= 1'b1;
            strobe_d  <= 1'b1;
            rst_pin_d <= 1'b1;
        end else if (clk_en) begin
            sclk_d    <= sclk;
            strobe_d  <= strobe_n;
            rst_pin_d <= rst_pin_n;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic strobe_fall;
    logic strobe_rise;
    assign sclk_rise   = sclk & ~sclk_d & ~strobe_n;
    assign sclk_fall   = ~sclk & sclk_d & ~strobe_n;
    assign strobe_fall = ~strobe_n & strobe_d;
    assign strobe_rise = strobe_n & ~strobe_d;

    // ----------------------------------------------------------------
    // Receive shifter
    // ----------------------------------------------------------------
    logic [15:0] rx_shift;
    logic [4:0]  rx_count;
    logic        word_done;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_shift <= 16'h0000;
        end else if (clk_en && sclk_rise) begin
            rx_shift <= {rx_shift[14:0], sdin};
        end
    end

    // Saturates so that a runaway clock cannot wrap back round to 16
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_count <= 5'h00;
        end else if (clk_en) begin
            if (strobe_fall)
                rx_count <= 5'h00;
            else if (sclk_rise && rx_count != 5'h1F)
                rx_count <= rx_count + 5'h01;
        end
    end

    assign word_done = strobe_rise && rx_count == 5'(`WORD_BITS);

    // Extra clocks spoil the word just as missing ones do
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_word <= '0;
        end else if (clk_en) begin
            rx_word.valid <= 1'b0;
            if (word_done) begin
                rx_word.valid <= 1'b1;
                rx_word.data  <= rx_shift;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault latch
    // ----------------------------------------------------------------
    logic clear_pulse;
    logic long_low;

    low_timer #(.LIMIT(SHUTDOWN_CYCLES)) u_sleep_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .level   (rst_pin_n),
        .expired (long_low)
    );

    assign clear_pulse = ~rst_pin_n & rst_pin_d;

    // A new fault wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            summary_fault_flag <= 1'b0;
        end else if (clk_en) begin
            if (fault_event)
                summary_fault_flag <= 1'b1;
            else if (clear_pulse)
                summary_fault_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            sleep <= 1'b0;
        else if (clk_en)
            sleep <= long_low;
    end

    // ----------------------------------------------------------------
    // Transmit shifter
    // ----------------------------------------------------------------
    logic [14:0] tx_shift;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_out_oe <= 1'b0;
        end else if (clk_en) begin
            serial_out_oe <= ~strobe_n;
        end
    end

    // Every clock fall moves one bit on, the first included: the host
    // must take the flag while the clock is still high after strobe fall
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_shift   <= 15'h0000;
            serial_out <= 1'b0;
        end else if (clk_en) begin
            if (strobe_fall) begin
                serial_out <= summary_fault_flag;
                tx_shift   <= diagnostic_out_bits;
            end else if (sclk_fall) begin
                serial_out <= tx_shift[14];
                tx_shift   <= {tx_shift[13:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate drive from PWM
    // ----------------------------------------------------------------
    logic brake;

    // Times the synchronised PWM, so braking starts two cycles late
    low_timer #(.LIMIT(BRAKE_CYCLES)) u_brake_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .level   (pwm),
        .expired (brake)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gate_drive <= '0;
        end else if (clk_en) begin
            if (sleep) begin
                gate_drive <= '0;
            end else if (brake && run_enable) begin
                gate_drive.high <= 3'h0;
                gate_drive.low  <= 3'h7;
            end else if (!pwm) begin
                gate_drive.high <= 3'h0;
                gate_drive.low  <= phase_low | phase_high;
            end else begin
                gate_drive.high <= phase_high;
                gate_drive.low  <= phase_low;
            end
        end
    end

    // ----------------------------------------------------------------
    // Diagnostic output
    // ----------------------------------------------------------------
    logic [DW-1:0] div_count;
    logic          timer_out;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_count <= '0;
        end else if (clk_en) begin
            if (div_count == DW'(TIMER_DIVIDE / 2 - 1))
                div_count <= '0;
            else
                div_count <= div_count + DW'(1);
        end
    end

    // Half the ratio per level keeps the output square
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_out <= 1'b0;
        end else if (clk_en && div_count == DW'(TIMER_DIVIDE / 2 - 1)) begin
            timer_out <= ~timer_out;
        end
    end

    // Core holds the select at its fault-flag reset value until written
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            diagnostic_out <= 1'b0;
        end else if (clk_en) begin
            unique case (diagnostic_select)
                DIAGNOSTIC_OUT_FAULT:   diagnostic_out <= summary_fault_flag;
                DIAGNOSTIC_OUT_TIMER:   diagnostic_out <= timer_out;
                DIAGNOSTIC_OUT_VDS:     diagnostic_out <= vds_level;
                DIAGNOSTIC_OUT_RUNNING: diagnostic_out <= sensorless_running;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Speed pulse
    // ----------------------------------------------------------------
    // A crossing in a commutating cycle wins, so no rise is ever lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            speed_pulse_out <= 1'b0;
        end else if (clk_en) begin
            if (zero_cross)
                speed_pulse_out <= 1'b1;
            else if (commutate)
                speed_pulse_out <= 1'b0;
        end
    end

endmodule

// [tb/bldc_host_if_sva.sv]
// Port assertions for the motor controller host interface
`timescale 1ns/10ps
module bldc_host_if_sva #(
    parameter int BRAKE_CYCLES    = 50000,
    parameter int SHUTDOWN_CYCLES = 100000,
    parameter int TIMER_DIVIDE    = 400
) (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rst,
    // Serial port
    input wire logic                     access_strobe_n,
    input wire logic                     serial_out,
    input wire logic                     serial_out_oe,
    input wire bldc_host_pkg::word_t     rx_word,
    // Core side
    input wire logic                     run_enable,
    input wire bldc_host_pkg::diagnostic_out_sel_t diagnostic_select,
    input wire logic                     fault_event,
    input wire logic                     zero_cross,
    input wire logic                     commutate,
    // Pins and outputs
    input wire logic                     pwm_in,
    input wire logic                     fault_clear_sleep_n,
    input wire bldc_host_pkg::gate_t     gate_drive,
    input wire logic                     sleep,
    input wire logic                     summary_fault_flag,
    input wire logic                     diagnostic_out,
    input wire logic                     speed_pulse_out
);
    import bldc_host_pkg::*;
    // ----------------
    // Helper counters
    // ----------------
    int   pwm_low, pin_low, sel_t, stay;
    logic prev_diagnostic_out, seen_zc;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk) begin
        pwm_low   <= (rst || pwm_in) ? 0 : pwm_low + 1;
        pin_low   <= (rst || fault_clear_sleep_n) ? 0 : pin_low + 1;
        sel_t     <= (rst || diagnostic_select != DIAGNOSTIC_OUT_TIMER) ? 0 : sel_t + 1;
        prev_diagnostic_out <= diagnostic_out;
        stay      <= (diagnostic_out != prev_diagnostic_out) ? 1 : stay + 1;
        seen_zc   <= !rst && (seen_zc || zero_cross);
    end
    // ----------------
    // Assertions
    // ----------------
    a_oe_idle_off: assert property (access_strobe_n [*6] |->
        !serial_out_oe) else $error("serial_out driven, strobe high");
    a_flag_first: assert property ($fell(access_strobe_n) |-> ##[1:4]
        (serial_out_oe && serial_out == summary_fault_flag))
        else $error("fault flag not shown at strobe fall");
    a_word_at_end: assert property (rx_word.valid |->
        access_strobe_n && $past(access_strobe_n))
        else $error("word applied with strobe low");
    a_chop_high_off: assert property (!pwm_in [*5] |->
        gate_drive.high == 3'h0) else $error("high side on, pwm low");
    a_brake_all_low: assert property (pwm_low > BRAKE_CYCLES + 4 &&
        run_enable && !sleep |-> gate_drive.low == 3'h7)
        else $error("no brake after long pwm low");
    a_sleep_entry: assert property (pin_low > SHUTDOWN_CYCLES + 4
        |-> sleep) else $error("no sleep after long reset low");
    a_flag_clear: assert property ($fell(fault_clear_sleep_n) ##1
        !fault_event [*4] |-> !summary_fault_flag)
        else $error("fault flag not cleared");
    a_speed_rise: assert property (zero_cross |=> speed_pulse_out)
        else $error("speed pulse not set at crossing");
    a_speed_fall: assert property (commutate && !zero_cross |=>
        !speed_pulse_out) else $error("speed pulse not cleared");
    a_speed_quiet: assert property (!seen_zc |-> !speed_pulse_out)
        else $error("speed pulse before first crossing");
    a_timer_half: assert property (diagnostic_out != prev_diagnostic_out &&
        sel_t > TIMER_DIVIDE |-> stay >= TIMER_DIVIDE / 2 - 2)
        else $error("timer output toggles too fast");
    a_timer_moves: assert property (sel_t > TIMER_DIVIDE |->
        stay <= TIMER_DIVIDE / 2 + 2) else $error("timer output stuck");
endmodule

bind bldc_host_if bldc_host_if_sva #(
    .BRAKE_CYCLES(BRAKE_CYCLES),
    .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
    .TIMER_DIVIDE(TIMER_DIVIDE)
) sva_i (
    .ref_clk, .rst, .access_strobe_n, .serial_out, .serial_out_oe,
    .rx_word, .run_enable, .diagnostic_select, .fault_event,
    .zero_cross, .commutate, .pwm_in, .fault_clear_sleep_n,
    .gate_drive, .sleep, .summary_fault_flag, .diagnostic_out,
    .speed_pulse_out
);

// [tb/host_model.sv]
// Host model: drives the serial port and the PWM pin
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic  ref_clk,
    // Serial pins
    output logic       serial_clk,
    output logic       serial_in,
    output logic       access_strobe_n,
    input  wire logic  serial_out,
    // PWM
    output logic       pwm_in
);
    logic [15:0] rd;
    initial begin
        {serial_in, rd} = '0;
        {serial_clk, access_strobe_n, pwm_in} = 3'h7;
    end
    // Phases of five cycles leave room for the two-stage pin sync
    task automatic xfer(input logic [15:0] w, input int n, input logic sel);
        access_strobe_n = !sel;
        repeat (5) @(negedge ref_clk);
        // Output is read while the clock is still high, before each fall
        for (int i = 0; i < n; i++) begin
            rd = {rd[14:0], serial_out};
            serial_clk = 1'b0;
            serial_in = w[15 - (i % 16)];
            repeat (5) @(negedge ref_clk);
            serial_clk = 1'b1;
            repeat (5) @(negedge ref_clk);
        end
        access_strobe_n = 1'b1;
        serial_in = !serial_in;
        repeat (5) @(negedge ref_clk);
    endtask
endmodule

// [tb/bldc_host_if_bench.sv]
// Self-checking bench for the motor controller host interface
`timescale 1ns/10ps
module bldc_host_if_bench;
    import bldc_host_pkg::*;
    localparam int BRK = 20;
    localparam int SHD = 40;
    localparam int TDIV = 400;
    logic        ref_clk, rst, run_enable, fault_event, sensorless_running;
    logic        vds_level, zero_cross, commutate, fault_clear_sleep_n;
    logic        serial_clk, serial_in, access_strobe_n, pwm_in, serial_out;
    logic        serial_out_oe, sleep, summary_fault_flag, diagnostic_out;
    logic        speed_pulse_out, flag, sp;
    logic [14:0] diagnostic_out_bits;
    logic [2:0]  phase_high, phase_low;
    logic [15:0] got;
    diagnostic_out_sel_t   diagnostic_select;
    word_t       rx_word;
    gate_t       gate_drive;
    int          got_n, n0, n_mismatch, cmp_count, seed, i, k;

    bldc_host_if #(.BRAKE_CYCLES(BRK), .SHUTDOWN_CYCLES(SHD),
        .TIMER_DIVIDE(TDIV)) dut (
        .ref_clk, .rst, .clk_en(1'b1), .serial_clk, .serial_in,
        .access_strobe_n, .serial_out, .serial_out_oe, .rx_word,
        .run_enable, .diagnostic_select, .diagnostic_out_bits, .fault_event,
        .sensorless_running, .vds_level, .phase_high, .phase_low,
        .zero_cross, .commutate, .pwm_in, .fault_clear_sleep_n,
        .gate_drive, .sleep, .summary_fault_flag, .diagnostic_out,
        .speed_pulse_out);
    // A released line reads inverted, so a late or early enable shows up
    host_model h (.ref_clk, .serial_clk, .serial_in, .access_strobe_n,
        .serial_out(serial_out_oe ? serial_out : !serial_out), .pwm_in);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (rx_word.valid === 1'b1) begin
            got <= rx_word.data;
            got_n <= got_n + 1;
        end
    end
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        cmp_count++;
        if (exp !== seen) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    function automatic logic [2:0] exp_low(input logic brake);
        return brake ? 3'h7 : (phase_high | phase_low);
    endfunction
    function automatic logic exp_diagnostic_out(input diagnostic_out_sel_t s);
        case (s)
            DIAGNOSTIC_OUT_FAULT:   return flag;
            DIAGNOSTIC_OUT_RUNNING: return sensorless_running;
            default:      return vds_level;
        endcase
    endfunction
    task automatic word(input logic [15:0] v, input int n, input logic sel,
                        input logic take);
        n0 = got_n;
        h.xfer(v, n, sel);
        for (k = 0; k < 20 && got_n == n0; k++) cyc(1);
        chk("word count", 16'(take), 16'(got_n - n0));
        if (take && got_n == n0) wrap_up();
        if (take) begin
            chk("rx data", v, got);
            chk("read back", {flag, diagnostic_out_bits}, h.rd);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        seed = 32'h3E76DBE1;
        {run_enable, fault_event, sensorless_running, vds_level} = '0;
        {zero_cross, commutate, diagnostic_out_bits, phase_high, phase_low} = '0;
        {got_n, n_mismatch, cmp_count, flag, sp, got} = '0;
        diagnostic_select = DIAGNOSTIC_OUT_FAULT;
        fault_clear_sleep_n = 1'b1;
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(3);
        for (i = 0; i < 60; i++) begin
            zero_cross = (i >= 20) && ($random(seed) % 4 == 0);
            commutate = ($random(seed) % 3 == 0);
            sp = zero_cross ? 1'b1 : (commutate ? 1'b0 : sp);
            cyc(1);
            chk("speed", 16'(sp), 16'(speed_pulse_out));
        end
        {zero_cross, commutate} = 2'h0;
        diagnostic_out_bits = 15'h2AAA;
        word(16'h8001, 16, 1'b1, 1'b1);
        fault_event = 1'b1;
        cyc(1);
        fault_event = 1'b0;
        flag = 1'b1;
        cyc(2);
        for (i = 0; i < 4; i++) begin
            diagnostic_out_bits = 15'($random(seed));
            word(16'($random(seed)), 16, 1'b1, 1'b1);
        end
        word(16'hFFFF, 15, 1'b1, 1'b0);
        word(16'h1234, 17, 1'b1, 1'b0);
        word(16'h5678, 16, 1'b0, 1'b0);
        chk("oe idle", 16'h0000, 16'(serial_out_oe));
        // Short pulse clears, long low sleeps
        fault_clear_sleep_n = 1'b0;
        cyc(3);
        fault_clear_sleep_n = 1'b1;
        flag = 1'b0;
        cyc(4);
        chk("flag", 16'(flag), 16'(summary_fault_flag));
        chk("awake", 16'h0000, 16'(sleep));
        {phase_high, phase_low} = 6'h2A;
        fault_clear_sleep_n = 1'b0;
        cyc(SHD + 8);
        chk("sleep", 16'h0001, 16'(sleep));
        chk("gates", 16'h0000, 16'(gate_drive));
        fault_clear_sleep_n = 1'b1;
        cyc(5);
        for (i = 0; i < 4; i++) begin
            run_enable = i[0];
            phase_high = 3'($random(seed));
            phase_low = 3'($random(seed));
            h.pwm_in = 1'b0;
            cyc(5);
            chk("chop high", 16'h0000, 16'(gate_drive.high));
            chk("chop low", 16'(exp_low(1'b0)), 16'(gate_drive.low));
            cyc(BRK + 5);
            chk("brake", 16'(exp_low(run_enable)), 16'(gate_drive.low));
            h.pwm_in = 1'b1;
            cyc(5);
        end
        for (i = 0; i < 8; i++) begin
            sensorless_running = i[2];
            vds_level = !i[2];
            diagnostic_select = diagnostic_out_sel_t'(i[1:0]);
            cyc(3);
            if (diagnostic_select != DIAGNOSTIC_OUT_TIMER) begin
                chk("diagnostic_out", 16'(exp_diagnostic_out(diagnostic_select)),
                    16'(diagnostic_out));
            end
        end
        diagnostic_select = DIAGNOSTIC_OUT_TIMER;
        cyc(5);
        k = 0;
        for (i = 0; i < 2 * TDIV; i++) begin
            sp = diagnostic_out;
            cyc(1);
            k += (sp !== diagnostic_out);
        end
        chk("timer edges", 16'h0004, 16'(k));
        wrap_up();
    end
endmodule
